//--- hw/lpc_pkg.sv
// Constants, register map and mode type of the LIN physical layer control
package lpc_pkg;

   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;

   // Register offsets
   localparam logic [ADDR_W-1:0] CTRL_ADDR   = 4'h0;
   localparam logic [ADDR_W-1:0] IRQEN_ADDR  = 4'h1;
   localparam logic [ADDR_W-1:0] FLAG_ADDR   = 4'h2;
   localparam logic [ADDR_W-1:0] STATUS_ADDR = 4'h3;

   // Control register fields
   localparam int PHY_ENABLE_BIT     = 0;
   localparam int RX_ONLY_BIT        = 1;
   localparam int STRONG_PULLUP_BIT  = 2;
   localparam int WAKE_ENABLE_BIT    = 3;
   localparam int DT_DISABLE_BIT     = 4;
   localparam int CTRL_W             = 5;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;

   // Interrupt enable and flag fields share positions
   localparam int DT_BIT = 7;
   localparam int OC_BIT = 6;

   // Status register fields
   localparam int STAT_DT_BIT    = 7;
   localparam int STAT_TXEN_BIT  = 3;
   localparam int STAT_MODE_LSB  = 0;

   // Clock and oscillator timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int RC_PERIOD_NS  = 1000;
   localparam int TICK_CYCLES   = RC_PERIOD_NS / CLK_PERIOD_NS;
   localparam int TICK_W        = $clog2(TICK_CYCLES);

   // Fault and wake times in oscillator periods (us)
   localparam int OC_MASK_US     = 3;
   localparam int DT_LIMIT_US    = 8000;
   localparam int WAKE_FILTER_US = 100;
   localparam int BIT_TIME_US    = 50;
   localparam int CNT_W          = 16;

   // Oscillator periods waited before a re-enable is judged
   localparam logic [1:0] RETRY_TICKS = 2'h2;

   typedef enum logic [2:0] {
      LPC_SHUTDOWN,
      LPC_NORMAL,
      LPC_RX_ONLY,
      LPC_STANDBY
   } lpc_mode_e;

endpackage

//--- hw/lpc_pin_if.sv
// Synchronised pins and oscillator tick between the control modules
`timescale 1ns/1ps
`default_nettype none
interface lpc_pin_if;
   logic tick;
   logic bus_level;
   logic overcurrent;
   modport source (output tick, output bus_level, output overcurrent);
   modport sink   (input tick, input bus_level, input overcurrent);
endinterface
`default_nettype wire

//--- hw/lpc_pin_sync.sv
// Pin synchronisers and oscillator tick generator
`timescale 1ns/1ps
`default_nettype none
module lpc_pin_sync
   import lpc_pkg::*;
(
   // Clock and reset
   input  wire logic    clk,
   input  wire logic    rst_n,
   // Raw analog comparator outputs
   input  wire logic    bus_level_raw,
   input  wire logic    overcurrent_raw,
   // To control logic
   lpc_pin_if.source    pins
);
   logic [1:0]        bus_sync_reg;
   logic [1:0]        oc_sync_reg;
   logic [TICK_W-1:0] tick_cnt_reg;
   logic              tick_reg;

   // Bus idles recessive, so reset to one
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_sync_reg <= 2'h3;
         oc_sync_reg  <= 2'h0;
      end else begin
         bus_sync_reg <= {bus_sync_reg[0], bus_level_raw};
         oc_sync_reg  <= {oc_sync_reg[0], overcurrent_raw};
      end
   end

   // Stands in for the internal RC oscillator period
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_cnt_reg <= '0;
         tick_reg     <= 1'b0;
      end else if (tick_cnt_reg == TICK_W'(TICK_CYCLES - 1)) begin
         tick_cnt_reg <= '0;
         tick_reg     <= 1'b1;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 1'b1;
         tick_reg     <= 1'b0;
      end
   end

   assign pins.tick        = tick_reg;
   assign pins.bus_level   = bus_sync_reg[1];
   assign pins.overcurrent = oc_sync_reg[1];
endmodule
`default_nettype wire

//--- hw/lpc_top.sv
// LIN physical layer mode and transmitter fault control
//
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module lpc_top
   import lpc_pkg::*;
#(
   parameter int OC_MASK_TICKS  = OC_MASK_US,
   parameter int DT_LIMIT_TICKS = DT_LIMIT_US,
   parameter int WAKE_TICKS     = WAKE_FILTER_US,
   parameter int BIT_TICKS      = BIT_TIME_US
) (
   // Clock and reset
   input  wire logic                       SYS_CLK,
   input  wire logic                       RSTN,
   // Register port
   input  wire logic [lpc_pkg::ADDR_W-1:0] ADDR,
   input  wire logic [lpc_pkg::DATA_W-1:0] WDATA,
   input  wire logic                       WR,
   input  wire logic                       RD,
   output logic      [lpc_pkg::DATA_W-1:0] RDATA,
   // Chip and serial interface side
   input  wire logic                       STOP_MODE,
   input  wire logic                       PHY_TRANSMIT_LINE,
   output logic                            PHY_RECEIVE_LINE,
   output logic                            WAKE_PULSE,
   output logic                            PHY_COMBINED_IRQ,
   // Analog front end
   input  wire logic                       BUS_LEVEL,
   input  wire logic                       OVERCURRENT,
   output logic                            TX_ENABLE,
   output logic                            RX_ENABLE,
   output logic                            RX_LOW_POWER,
   output logic                            STRONG_PULLUP
);
   import lpc_pkg::*;

   function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] cnt,
                                                input int lim);
      sat_inc = (cnt >= CNT_W'(lim)) ? cnt : cnt + 1'b1;
   endfunction

   lpc_pin_if pins ();

   lpc_pin_sync u_sync (
      .clk             (SYS_CLK),
      .rst_n           (RSTN),
      .bus_level_raw   (BUS_LEVEL),
      .overcurrent_raw (OVERCURRENT),
      .pins            (pins)
   );

   lpc_mode_e         mode_reg;
   lpc_mode_e         mode_next;
   logic [CTRL_W-1:0] ctrl_reg;
   logic              dt_ie_reg;
   logic              oc_ie_reg;
   logic              dt_flag_reg;
   logic              oc_flag_reg;
   logic              dt_status_reg;
   logic              dt_fault_reg;
   logic              oc_fault_reg;
   logic              txd_prev_reg;
   logic [CNT_W-1:0]  mask_cnt_reg;
   logic [CNT_W-1:0]  dom_cnt_reg;
   logic [CNT_W-1:0]  qual_cnt_reg;
   logic [CNT_W-1:0]  wake_cnt_reg;
   logic              bus_prev_reg;
   logic              oc_retry_reg;
   logic              dt_retry_reg;
   logic [1:0]        oc_wait_reg;
   logic [1:0]        dt_wait_reg;
   logic              oc_check_reg;
   logic              dt_check_reg;

   logic phy_enable;
   logic receive_only_select;
   logic strong_pullup_select;
   logic wake_enable;
   logic dominant_timeout_disable;
   logic tx_on;
   logic txd_dom;
   logic qual_ok;
   logic oc_event;
   logic dt_event;
   logic oc_clear;
   logic dt_clear;
   logic oc_refail;
   logic dt_refail;
   logic wr_ctrl;

   assign phy_enable               = ctrl_reg[PHY_ENABLE_BIT];
   assign receive_only_select      = ctrl_reg[RX_ONLY_BIT];
   assign strong_pullup_select     = ctrl_reg[STRONG_PULLUP_BIT];
   assign wake_enable              = ctrl_reg[WAKE_ENABLE_BIT];
   assign dominant_timeout_disable = ctrl_reg[DT_DISABLE_BIT];
   assign txd_dom                  = !PHY_TRANSMIT_LINE;
   assign wr_ctrl                  = WR && (ADDR == CTRL_ADDR);

   // Transmitter only drives in normal mode with no fault latched
   assign tx_on = (mode_reg == LPC_NORMAL) && !oc_fault_reg && !dt_fault_reg;

   // Register writes
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         ctrl_reg  <= CTRL_RESET;
         dt_ie_reg <= 1'b0;
         oc_ie_reg <= 1'b0;
      end else if (WR) begin
         if (ADDR == CTRL_ADDR) begin
            ctrl_reg <= WDATA[CTRL_W-1:0];
         end
         if (ADDR == IRQEN_ADDR) begin
            dt_ie_reg <= WDATA[DT_BIT];
            oc_ie_reg <= WDATA[OC_BIT];
         end
      end
   end

   // Mode state machine
   always_comb begin
      mode_next = mode_reg;
      case (mode_reg)
         LPC_SHUTDOWN: begin
            if (phy_enable) begin
               mode_next = receive_only_select ? LPC_RX_ONLY : LPC_NORMAL;
            end
         end
         LPC_NORMAL: begin
            if (!phy_enable) begin
               mode_next = LPC_SHUTDOWN;
            end else if (STOP_MODE) begin
               mode_next = LPC_STANDBY;
            end else if (receive_only_select) begin
               mode_next = LPC_RX_ONLY;
            end
         end
         LPC_RX_ONLY: begin
            if (!phy_enable) begin
               mode_next = LPC_SHUTDOWN;
            end else if (STOP_MODE) begin
               mode_next = LPC_STANDBY;
            end else if (!receive_only_select) begin
               mode_next = LPC_NORMAL;
            end
         end
         LPC_STANDBY: begin
            if (!STOP_MODE) begin
               mode_next = receive_only_select ? LPC_RX_ONLY : LPC_NORMAL;
            end
         end
         default: mode_next = LPC_SHUTDOWN;
      endcase
   end

   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         mode_reg <= LPC_SHUTDOWN;
      end else begin
         mode_reg <= mode_next;
      end
   end

   // Analog controls, all registered
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         TX_ENABLE     <= 1'b0;
         RX_ENABLE     <= 1'b0;
         RX_LOW_POWER  <= 1'b0;
         STRONG_PULLUP <= 1'b0;
      end else begin
         TX_ENABLE    <= tx_on;
         RX_ENABLE    <= (mode_reg == LPC_NORMAL) || (mode_reg == LPC_RX_ONLY) ||
                         ((mode_reg == LPC_STANDBY) && wake_enable);
         RX_LOW_POWER <= (mode_reg == LPC_STANDBY) && wake_enable;
         case (mode_reg)
            LPC_NORMAL:  STRONG_PULLUP <= strong_pullup_select;
            LPC_RX_ONLY: STRONG_PULLUP <= strong_pullup_select;
            LPC_STANDBY: STRONG_PULLUP <= wake_enable && strong_pullup_select;
            default:     STRONG_PULLUP <= 1'b0;
         endcase
      end
   end

   // Receive path; bus passes straight through once active again
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         PHY_RECEIVE_LINE <= 1'b1;
      end else if ((mode_reg == LPC_NORMAL) || (mode_reg == LPC_RX_ONLY)) begin
         PHY_RECEIVE_LINE <= pins.bus_level;
      end else begin
         PHY_RECEIVE_LINE <= 1'b1;
      end
   end

   // Wake filter: dominant for the filter time, then a rising edge
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         wake_cnt_reg <= '0;
         bus_prev_reg <= 1'b1;
         WAKE_PULSE   <= 1'b0;
      end else begin
         bus_prev_reg <= pins.bus_level;
         WAKE_PULSE   <= 1'b0;
         if ((mode_reg != LPC_STANDBY) || !wake_enable) begin
            wake_cnt_reg <= '0;
         end else if (!pins.bus_level) begin
            if (pins.tick) begin
               wake_cnt_reg <= sat_inc(wake_cnt_reg, WAKE_TICKS);
            end
         end else begin
            wake_cnt_reg <= '0;
            if (!bus_prev_reg && (wake_cnt_reg >= CNT_W'(WAKE_TICKS))) begin
               WAKE_PULSE <= 1'b1;
            end
         end
      end
   end

   // One bit time of recessive line or quiet mode qualifies a re-enable
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         qual_cnt_reg <= '0;
      end else if (!txd_dom || (mode_reg == LPC_SHUTDOWN) || (mode_reg == LPC_RX_ONLY)) begin
         if (pins.tick) begin
            qual_cnt_reg <= sat_inc(qual_cnt_reg, BIT_TICKS);
         end
      end else begin
         qual_cnt_reg <= '0;
      end
   end
   assign qual_ok = qual_cnt_reg >= CNT_W'(BIT_TICKS);

   // Overcurrent masking window after each falling edge
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         txd_prev_reg <= 1'b1;
         mask_cnt_reg <= '0;
      end else begin
         txd_prev_reg <= PHY_TRANSMIT_LINE;
         if (txd_prev_reg && !PHY_TRANSMIT_LINE) begin
            mask_cnt_reg <= '0;
         end else if (pins.tick) begin
            mask_cnt_reg <= sat_inc(mask_cnt_reg, OC_MASK_TICKS);
         end
      end
   end
   // Short bits never leave the window, so no overcurrent is reported
   assign oc_event = tx_on && pins.overcurrent &&
                     (mask_cnt_reg >= CNT_W'(OC_MASK_TICKS));

   // Dominant time counter, only watched in normal mode
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         dom_cnt_reg <= '0;
      end else if (txd_dom && (mode_reg == LPC_NORMAL) && !dominant_timeout_disable) begin
         if (pins.tick) begin
            dom_cnt_reg <= sat_inc(dom_cnt_reg, DT_LIMIT_TICKS);
         end
      end else begin
         dom_cnt_reg <= '0;
      end
   end
   assign dt_event = tx_on && (dom_cnt_reg >= CNT_W'(DT_LIMIT_TICKS));

   // Timeout status tracks the line after a timeout
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         dt_status_reg <= 1'b0;
      end else if (dt_event) begin
         dt_status_reg <= 1'b1;
      end else if (!txd_dom) begin
         dt_status_reg <= 1'b0;
      end
   end

   // Clear writes; software clears only set flags
   assign oc_clear  = WR && (ADDR == FLAG_ADDR) && WDATA[OC_BIT];
   assign dt_clear  = WR && (ADDR == FLAG_ADDR) && WDATA[DT_BIT];
   assign oc_refail = pins.overcurrent || !qual_ok || ((mode_reg == LPC_NORMAL) && txd_dom);
   assign dt_refail = dt_status_reg || !qual_ok || ((mode_reg == LPC_NORMAL) && txd_dom);

   // Re-enable wait: one to two oscillator periods plus two cycles
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         oc_retry_reg <= 1'b0;
         oc_wait_reg  <= 2'h0;
         oc_check_reg <= 1'b0;
      end else begin
         oc_check_reg <= 1'b0;
         if (oc_clear && oc_flag_reg) begin
            oc_retry_reg <= 1'b1;
            oc_wait_reg  <= 2'h0;
         end else if (oc_retry_reg && pins.tick) begin
            oc_wait_reg <= oc_wait_reg + 1'b1;
            if (oc_wait_reg == RETRY_TICKS - 2'h1) begin
               oc_retry_reg <= 1'b0;
               oc_check_reg <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         dt_retry_reg <= 1'b0;
         dt_wait_reg  <= 2'h0;
         dt_check_reg <= 1'b0;
      end else begin
         dt_check_reg <= 1'b0;
         if (dt_clear && dt_flag_reg) begin
            dt_retry_reg <= 1'b1;
            dt_wait_reg  <= 2'h0;
         end else if (dt_retry_reg && pins.tick) begin
            dt_wait_reg <= dt_wait_reg + 1'b1;
            if (dt_wait_reg == RETRY_TICKS - 2'h1) begin
               dt_retry_reg <= 1'b0;
               dt_check_reg <= 1'b1;
            end
         end
      end
   end

   // Overcurrent fault latch and flag; a set beats a clear
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         oc_fault_reg <= 1'b0;
         oc_flag_reg  <= 1'b0;
      end else begin
         if (oc_event) begin
            oc_fault_reg <= 1'b1;
            oc_flag_reg  <= 1'b1;
         end else if (oc_check_reg) begin
            if (oc_refail) begin
               oc_flag_reg <= 1'b1;
            end else begin
               oc_fault_reg <= 1'b0;
            end
         end else if (oc_clear) begin
            oc_flag_reg <= 1'b0;
         end
      end
   end

   // Timeout fault latch and flag; a set beats a clear
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         dt_fault_reg <= 1'b0;
         dt_flag_reg  <= 1'b0;
      end else begin
         if (dt_event) begin
            dt_fault_reg <= 1'b1;
            dt_flag_reg  <= 1'b1;
         end else if (dt_check_reg) begin
            if (dt_refail) begin
               dt_flag_reg <= 1'b1;
            end else begin
               dt_fault_reg <= 1'b0;
            end
         end else if (dt_clear) begin
            dt_flag_reg <= 1'b0;
         end
      end
   end

   // Combined interrupt request
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         PHY_COMBINED_IRQ <= 1'b0;
      end else begin
         PHY_COMBINED_IRQ <= (dt_flag_reg && dt_ie_reg) || (oc_flag_reg && oc_ie_reg);
      end
   end

   // Read data, one cycle after the strobe; unmapped reads as zero
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         RDATA <= '0;
      end else if (RD) begin
         RDATA <= '0;
         case (ADDR)
            CTRL_ADDR: RDATA[CTRL_W-1:0] <= ctrl_reg;
            IRQEN_ADDR: begin
               RDATA[DT_BIT] <= dt_ie_reg;
               RDATA[OC_BIT] <= oc_ie_reg;
            end
            FLAG_ADDR: begin
               RDATA[DT_BIT] <= dt_flag_reg;
               RDATA[OC_BIT] <= oc_flag_reg;
            end
            STATUS_ADDR: begin
               RDATA[STAT_DT_BIT]                 <= dt_status_reg;
               RDATA[STAT_TXEN_BIT]               <= tx_on;
               RDATA[STAT_MODE_LSB +: $bits(mode_reg)] <= mode_reg;
            end
            default: RDATA <= '0;
         endcase
      end else begin
         RDATA <= '0;
      end
   end

endmodule
`default_nettype wire

//--- test/lpc_top_properties.sv
// Port-level properties of the LIN physical layer control
`timescale 1ns/1ps
`default_nettype none
module lpc_top_properties (
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic RSTN,
   // Observed ports
   input wire logic STOP_MODE,
   input wire logic BUS_LEVEL,
   input wire logic PHY_RECEIVE_LINE,
   input wire logic WAKE_PULSE,
   input wire logic TX_ENABLE,
   input wire logic RX_ENABLE,
   input wire logic RX_LOW_POWER,
   input wire logic STRONG_PULLUP
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RSTN);
   // Two cycles of slack (four under STOP_MODE), all outputs follow one mode register
   rx_idle_line_a: assert property ((!RX_ENABLE) [*2] |-> PHY_RECEIVE_LINE)
      else $error("receive line not idle while receiver off");
   tx_needs_rx_a: assert property (TX_ENABLE |-> RX_ENABLE)
      else $error("transmitter on without receiver");
   lowpower_tx_off_a: assert property (RX_LOW_POWER |-> !TX_ENABLE)
      else $error("transmitter on in low power");
   stop_tx_off_a: assert property (STOP_MODE [*4] |-> !TX_ENABLE)
      else $error("transmitter on during stop");
   stop_rx_low_a: assert property (STOP_MODE [*4] |-> !RX_ENABLE || RX_LOW_POWER)
      else $error("receiver at full power during stop");
   weak_pullup_a: assert property ((!RX_ENABLE) [*2] |-> !STRONG_PULLUP)
      else $error("strong pull-up with receiver off");
   wake_single_a: assert property (WAKE_PULSE |=> !WAKE_PULSE)
      else $error("wake pulse longer than one cycle");
   wake_cause_a:
      assert property (WAKE_PULSE |-> BUS_LEVEL && !$past(BUS_LEVEL, 5))
      else $error("wake pulse without a dominant then rising bus");
endmodule
bind lpc_top lpc_top_properties chk (
   .SYS_CLK(SYS_CLK), .RSTN(RSTN), .STOP_MODE(STOP_MODE), .BUS_LEVEL(BUS_LEVEL),
   .PHY_RECEIVE_LINE(PHY_RECEIVE_LINE), .WAKE_PULSE(WAKE_PULSE), .TX_ENABLE(TX_ENABLE),
   .RX_ENABLE(RX_ENABLE), .RX_LOW_POWER(RX_LOW_POWER), .STRONG_PULLUP(STRONG_PULLUP));
`default_nettype wire

//--- test/lpc_lin_bus.sv
// Behavioural LIN bus with pull-up, foreign node and short circuit
`timescale 1ns/1ps
`default_nettype none
module lpc_lin_bus (
   // Transceiver side
   input  wire logic tx_enable,
   input  wire logic tx_line,
   // Scenario controls
   input  wire logic ext_dominant,
   input  wire logic short_on,
   // Comparator outputs
   output logic      bus_level,
   output logic      overcurrent
);
   logic driving;
   assign driving = tx_enable && !tx_line;
   // Pull-up makes a released bus recessive
   assign bus_level = !(driving || ext_dominant);
   // A short only draws current while our driver pulls low
   assign overcurrent = short_on && driving;
endmodule
`default_nettype wire

//--- test/lpc_top_bench.sv
// Register-driven scenarios for the LIN physical layer control
`timescale 1ns/1ps
`default_nettype none
module lpc_top_bench;
   import lpc_pkg::*;
   logic              clk = 1'b0;
   logic              rst_n = 1'b0;
   logic [ADDR_W-1:0] addr = 4'h0;
   logic [DATA_W-1:0] wdata = 8'h00;
   logic              wr = 1'b0;
   logic              rd = 1'b0;
   logic              stop = 1'b0;
   logic              txl = 1'b1;
   logic              ext = 1'b0;
   logic              shrt = 1'b0;
   logic [DATA_W-1:0] rdata;
   logic              rxl, wake, irq, bus, oc, txen, rxen, lowp, pup, seen;
   int                n_mismatch = 0;
   int                num_checks = 0;
   int                cyc = 0;
   always #5 clk = ~clk;
   // Short limits keep the run brief
   lpc_top #(.DT_LIMIT_TICKS(20), .WAKE_TICKS(5), .BIT_TICKS(5)) dut (
      .SYS_CLK(clk), .RSTN(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
      .RDATA(rdata), .STOP_MODE(stop), .PHY_TRANSMIT_LINE(txl), .PHY_RECEIVE_LINE(rxl),
      .WAKE_PULSE(wake), .PHY_COMBINED_IRQ(irq), .BUS_LEVEL(bus), .OVERCURRENT(oc),
      .TX_ENABLE(txen), .RX_ENABLE(rxen), .RX_LOW_POWER(lowp), .STRONG_PULLUP(pup));
   lpc_lin_bus lin (.tx_enable(txen), .tx_line(txl), .ext_dominant(ext), .short_on(shrt),
      .bus_level(bus), .overcurrent(oc));
   task automatic conclude;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         n_mismatch++;
         conclude();
      end
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk($sformatf("reg %0h", a), e, rdata);
   endtask
   // Order: tx, rx, low power, strong pull-up, receive line, irq
   task automatic pins(input logic [5:0] e);
      #1;
      chk("pins", {2'b00, e}, {2'b00, txen, rxen, lowp, pup, rxl, irq});
   endtask
   initial begin
      tick(5);
      rst_n <= 1'b1;
      pins(6'b000010);
      rd_reg(CTRL_ADDR, 8'h00);
      rd_reg(STATUS_ADDR, 8'h00);
      wr_reg(4'h7, 8'hff);
      rd_reg(4'h7, 8'h00);
      wr_reg(CTRL_ADDR, 8'h07);
      tick(4);
      pins(6'b010110);
      rd_reg(STATUS_ADDR, 8'h02);
      wr_reg(CTRL_ADDR, 8'h05);
      tick(4);
      pins(6'b110110);
      rd_reg(STATUS_ADDR, 8'h09);
      wr_reg(CTRL_ADDR, 8'h07);
      tick(4);
      rd_reg(STATUS_ADDR, 8'h02);
      wr_reg(CTRL_ADDR, 8'h01);
      wr_reg(IRQEN_ADDR, 8'hc0);
      tick(4);
      pins(6'b110010);
      // Dominant timeout, failed and good re-enable
      @(posedge clk) txl <= 1'b0;
      tick(2500);
      rd_reg(FLAG_ADDR, 8'h80);
      rd_reg(STATUS_ADDR, 8'h81);
      pins(6'b010011);
      wr_reg(IRQEN_ADDR, 8'h40);
      tick(3);
      pins(6'b010010);
      wr_reg(IRQEN_ADDR, 8'hc0);
      wr_reg(FLAG_ADDR, 8'h00);
      rd_reg(FLAG_ADDR, 8'h80);
      wr_reg(FLAG_ADDR, 8'h80);
      rd_reg(FLAG_ADDR, 8'h00);
      tick(300);
      rd_reg(FLAG_ADDR, 8'h80);
      @(posedge clk) txl <= 1'b1;
      tick(4);
      rd_reg(STATUS_ADDR, 8'h01);
      tick(700);
      wr_reg(FLAG_ADDR, 8'h80);
      tick(300);
      rd_reg(FLAG_ADDR, 8'h00);
      rd_reg(STATUS_ADDR, 8'h09);
      wr_reg(CTRL_ADDR, 8'h11);
      txl <= 1'b0;
      tick(2500);
      rd_reg(FLAG_ADDR, 8'h00);
      rd_reg(STATUS_ADDR, 8'h09);
      @(posedge clk) txl <= 1'b1;
      wr_reg(CTRL_ADDR, 8'h01);
      // Overcurrent inside, then outside, the mask window
      txl <= 1'b0;
      tick(50);
      shrt <= 1'b1;
      tick(100);
      shrt <= 1'b0;
      rd_reg(FLAG_ADDR, 8'h00);
      tick(300);
      shrt <= 1'b1;
      tick(10);
      rd_reg(FLAG_ADDR, 8'h40);
      pins(6'b010011);
      @(posedge clk) shrt <= 1'b0;
      wr_reg(FLAG_ADDR, 8'h40);
      tick(300);
      rd_reg(FLAG_ADDR, 8'h40);
      @(posedge clk) txl <= 1'b1;
      tick(700);
      wr_reg(FLAG_ADDR, 8'h40);
      tick(300);
      rd_reg(FLAG_ADDR, 8'h00);
      pins(6'b110010);
      // Standby with wake, then without, then leave stop
      wr_reg(CTRL_ADDR, 8'h0d);
      tick(4);
      stop <= 1'b1;
      tick(5);
      pins(6'b011110);
      rd_reg(STATUS_ADDR, 8'h03);
      @(posedge clk) ext <= 1'b1;
      tick(700);
      ext <= 1'b0;
      seen = 1'b0;
      repeat (20) begin
         @(posedge clk);
         #1;
         seen = seen | wake;
      end
      chk("wake", 8'h01, {7'h00, seen});
      wr_reg(CTRL_ADDR, 8'h07);
      tick(4);
      pins(6'b000010);
      @(posedge clk) ext <= 1'b1;
      tick(4);
      stop <= 1'b0;
      tick(8);
      rd_reg(STATUS_ADDR, 8'h02);
      // Receive-only keeps the selected strong pull-up
      pins(6'b010100);
      @(posedge clk) ext <= 1'b0;
      wr_reg(CTRL_ADDR, 8'h00);
      tick(4);
      rd_reg(STATUS_ADDR, 8'h00);
      pins(6'b000010);
      conclude();
   end
endmodule
`default_nettype wire
